// file: hw/fcsir_params.svh
// Functional notes
// - Divider writes accepted during reset sequence.
// - Tabulated codes give timing clock within limits.
// - Security register readable, writes have no effect.
// - Security register loaded from nonvolatile byte.
// - Double fault at load sets all bits.
// - Backdoor enabled only for field value 10; the unlock input forces the lock field whatever the key field holds.
// - Unsecured only when lock field equals 10.
// - Backdoor unsecure forces lock field to 10.
// - Command index readable, writable, upper bits zero.
// - ECC index readable, writable, upper bits zero.
// - Divide bits write once, loaded flag read-only.
`ifndef FCSIR_PARAMS_SVH
`define FCSIR_PARAMS_SVH
// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define FCSIR_OFS_CLKDIV 5'h00
`define FCSIR_OFS_SEC 5'h01
`define FCSIR_OFS_CMDIX 5'h02
`define FCSIR_OFS_ECCIX 5'h03
// ------------------------------------------------------------
// Fields and values
// ------------------------------------------------------------
`define FCSIR_IX_MSB 2
`define FCSIR_DIV_MSB 6
`define FCSIR_LOADED_BIT 7
`define FCSIR_KEY_MSB 7
`define FCSIR_KEY_LSB 6
`define FCSIR_LOCK_MSB 1
`define FCSIR_LOCK_LSB 0
`define FCSIR_ENABLE_CODE 2'h2
`define FCSIR_UNSECURE_CODE 2'h2
`define FCSIR_SEC_FAULT 8'hFF
`define FCSIR_SEC_NV_ADDR 23'h7FFF0F
`define FCSIR_ZERO8 8'h00
`define FCSIR_RSV_LSB 2
`define FCSIR_DIV_RST 7'h00
`define FCSIR_IX_RST 3'h0
`define FCSIR_IX_PAD 5'h00
`endif

// file: hw/fcsir_pkg.sv
package fcsir_pkg;
   typedef enum logic [2:0]
   {
      FCSIR_ST_RESET = 3'h1,
      FCSIR_ST_LOAD = 3'h2,
      FCSIR_ST_RUN = 3'h4
   } fcsir_state_t;
endpackage

// file: hw/fcsir_regs.sv
// Decided for this implementation: strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "fcsir_params.svh"
module fcsir_regs
(
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic [4:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic command_complete_flag_i,
   output logic nv_rd_req_o,
   output logic [22:0] nv_addr_o,
   input wire logic nv_rd_valid_i,
   input wire logic [7:0] nv_rd_data_i,
   input wire logic nv_dbl_fault_i,
   input wire logic backdoor_unlock_i,
   output logic reset_seq_o,
   output logic [6:0] divide_ratio_field_o,
   output logic divider_loaded_flag_o,
   output logic backdoor_enabled_o,
   output logic part_secured_o,
   output logic [2:0] cmd_object_index_o,
   output logic [2:0] ecc_result_index_o
);
   fcsir_pkg::fcsir_state_t state_q;
   logic [7:0] sec_q;
   logic [6:0] div_q;
   logic loaded_q;
   logic [2:0] cmd_ix_q;
   logic [2:0] ecc_ix_q;
   logic [7:0] rdata_q;
   logic wr_div;
   logic wr_cmdix;
   logic wr_eccix;

   function automatic logic is_code(input logic [1:0] v, input logic [1:0] c);
      is_code = (v == c);
   endfunction

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   function automatic logic is_ofs(input logic [4:0] a, input logic [4:0] o);
      is_ofs = (a == o);
   endfunction

   // One decode per target keeps the write paths and the hold checks in step
   assign wr_div = wr_i && is_ofs(addr_i, `FCSIR_OFS_CLKDIV);
   assign wr_cmdix = wr_i && is_ofs(addr_i, `FCSIR_OFS_CMDIX);
   assign wr_eccix = wr_i && is_ofs(addr_i, `FCSIR_OFS_ECCIX);

   // ------------------------------------------------------------
   // Reset sequence: fetch security byte once
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
         state_q <= fcsir_pkg::FCSIR_ST_RESET;
      else
      begin
         case (state_q)
            fcsir_pkg::FCSIR_ST_RESET: state_q <= fcsir_pkg::FCSIR_ST_LOAD;
            fcsir_pkg::FCSIR_ST_LOAD:
               if (nv_rd_valid_i)
                  state_q <= fcsir_pkg::FCSIR_ST_RUN;
            fcsir_pkg::FCSIR_ST_RUN: state_q <= fcsir_pkg::FCSIR_ST_RUN;
            default: state_q <= fcsir_pkg::FCSIR_ST_RESET;
         endcase
      end
   end

   assign nv_rd_req_o = (state_q == fcsir_pkg::FCSIR_ST_LOAD);
   assign nv_addr_o = `FCSIR_SEC_NV_ADDR;
   assign reset_seq_o = (state_q != fcsir_pkg::FCSIR_ST_RUN);

   // ------------------------------------------------------------
   // Security register
   // ------------------------------------------------------------
   // Faulted fetch must never leave the part open, so all ones wins
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
         sec_q <= `FCSIR_SEC_FAULT;
      else if (nv_rd_req_o && nv_rd_valid_i)
      begin
         if (nv_dbl_fault_i)
            sec_q <= `FCSIR_SEC_FAULT;
         else
            sec_q <= nv_rd_data_i;
      end
      else if (backdoor_unlock_i && !reset_seq_o)
         sec_q[`FCSIR_LOCK_MSB:`FCSIR_LOCK_LSB] <= `FCSIR_UNSECURE_CODE;
   end
   // Bus writes never reach sec_q

   assign backdoor_enabled_o =
      is_code(sec_q[`FCSIR_KEY_MSB:`FCSIR_KEY_LSB], `FCSIR_ENABLE_CODE);
   assign part_secured_o =
      !is_code(sec_q[`FCSIR_LOCK_MSB:`FCSIR_LOCK_LSB], `FCSIR_UNSECURE_CODE);

   // ------------------------------------------------------------
   // Clock divider, write once
   // ------------------------------------------------------------
   // Not gated by the complete flag: keeping off busy writes is software's job
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         div_q <= `FCSIR_DIV_RST;
         loaded_q <= 1'b0;
      end
      else if (wr_div && !loaded_q)
      begin
         div_q <= wdata_i[`FCSIR_DIV_MSB:0];
         loaded_q <= 1'b1;
      end
   end

   // The timing divider downstream meets its limits only with tabulated codes
   assign divide_ratio_field_o = div_q;
   assign divider_loaded_flag_o = loaded_q;

   // ------------------------------------------------------------
   // Index registers
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
      begin
         cmd_ix_q <= `FCSIR_IX_RST;
         ecc_ix_q <= `FCSIR_IX_RST;
      end
      else
      begin
         if (wr_cmdix)
            cmd_ix_q <= wdata_i[`FCSIR_IX_MSB:0];
         if (wr_eccix)
            ecc_ix_q <= wdata_i[`FCSIR_IX_MSB:0];
      end
   end

   assign cmd_object_index_o = cmd_ix_q;
   assign ecc_result_index_o = ecc_ix_q;

   // ------------------------------------------------------------
   // Read data, one cycle after the strobe
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i)
   begin
      if (rst_i)
         rdata_q <= `FCSIR_ZERO8;
      else if (rd_i)
      begin
         case (addr_i)
            `FCSIR_OFS_CLKDIV: rdata_q <= {loaded_q, div_q};
            `FCSIR_OFS_SEC: rdata_q <= sec_q;
            `FCSIR_OFS_CMDIX: rdata_q <= {`FCSIR_IX_PAD, cmd_ix_q};
            `FCSIR_OFS_ECCIX: rdata_q <= {`FCSIR_IX_PAD, ecc_ix_q};
            default: rdata_q <= `FCSIR_ZERO8;
         endcase
      end
      else
         rdata_q <= `FCSIR_ZERO8;
   end

   assign rdata_o = rdata_q;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_div_once;
      @(posedge core_clk_i) disable iff (rst_i)
      loaded_q |=> $stable(div_q);
   endproperty
   a_div_once: assert property (p_div_once) else $error("divider changed after load");

   property p_div_load;
      @(posedge core_clk_i) disable iff (rst_i)
      (wr_i && addr_i == `FCSIR_OFS_CLKDIV && !loaded_q)
      |=> (loaded_q && div_q == $past(wdata_i[`FCSIR_DIV_MSB:0]));
   endproperty
   a_div_load: assert property (p_div_load) else $error("divider write lost");

   property p_sec_ro;
      @(posedge core_clk_i) disable iff (rst_i)
      (wr_i && !reset_seq_o && !backdoor_unlock_i) |=> $stable(sec_q);
   endproperty
   a_sec_ro: assert property (p_sec_ro) else $error("security changed by write");

   property p_sec_fault;
      @(posedge core_clk_i) disable iff (rst_i)
      (nv_rd_req_o && nv_rd_valid_i && nv_dbl_fault_i) |=> (sec_q == `FCSIR_SEC_FAULT);
   endproperty
   a_sec_fault: assert property (p_sec_fault) else $error("fault did not secure");

   property p_sec_load;
      @(posedge core_clk_i) disable iff (rst_i)
      (nv_rd_req_o && nv_rd_valid_i && !nv_dbl_fault_i) |=> (sec_q == $past(nv_rd_data_i));
   endproperty
   a_sec_load: assert property (p_sec_load) else $error("security byte not loaded");

   property p_key;
      @(posedge core_clk_i) disable iff (rst_i)
      backdoor_enabled_o == (sec_q[`FCSIR_KEY_MSB] && !sec_q[`FCSIR_KEY_LSB]);
   endproperty
   a_key: assert property (p_key) else $error("backdoor decode wrong");

   property p_lock;
      @(posedge core_clk_i) disable iff (rst_i)
      part_secured_o == !(sec_q[`FCSIR_LOCK_MSB] && !sec_q[`FCSIR_LOCK_LSB]);
   endproperty
   a_lock: assert property (p_lock) else $error("lock decode wrong");

   property p_unlock;
      @(posedge core_clk_i) disable iff (rst_i)
      (backdoor_unlock_i && !reset_seq_o) |=> !part_secured_o;
   endproperty
   a_unlock: assert property (p_unlock) else $error("unlock not forced");

   property p_cmdix;
      @(posedge core_clk_i) disable iff (rst_i)
      (rd_i && addr_i == `FCSIR_OFS_CMDIX) |=> (rdata_o == {`FCSIR_IX_PAD, $past(cmd_ix_q)});
   endproperty
   a_cmdix: assert property (p_cmdix) else $error("command index readback wrong");

   property p_eccix;
      @(posedge core_clk_i) disable iff (rst_i)
      (wr_i && addr_i == `FCSIR_OFS_ECCIX) ##1 (rd_i && addr_i == `FCSIR_OFS_ECCIX)
      |=> (rdata_o == {`FCSIR_IX_PAD, $past(wdata_i[`FCSIR_IX_MSB:0], 2)});
   endproperty
   a_eccix: assert property (p_eccix) else $error("ecc index readback wrong");

   c_fault: cover property (@(posedge core_clk_i) nv_rd_valid_i && nv_dbl_fault_i);
   c_div_twice: cover property (@(posedge core_clk_i)
      loaded_q && wr_i && addr_i == `FCSIR_OFS_CLKDIV);
   c_unlock: cover property (@(posedge core_clk_i) backdoor_unlock_i && part_secured_o);
   c_div_in_reset: cover property (@(posedge core_clk_i)
      wr_div && reset_seq_o && !command_complete_flag_i);
   c_seq_done: cover property (@(posedge core_clk_i) $fell(reset_seq_o));

   // ------------------------------------------------------------
   // Read path and hold checks
   // ------------------------------------------------------------
   // An idle bus must read zero, so stale data never hides a lost strobe
   property p_rdata_idle;
      @(posedge core_clk_i) disable iff (rst_i)
      !rd_i |=> (rdata_o == `FCSIR_ZERO8);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");

   property p_div_rd;
      @(posedge core_clk_i) disable iff (rst_i)
      (rd_i && addr_i == `FCSIR_OFS_CLKDIV)
      |=> (rdata_o == {$past(loaded_q), $past(div_q)});
   endproperty
   a_div_rd: assert property (p_div_rd) else $error("divider readback wrong");

   property p_div_hold;
      @(posedge core_clk_i) disable iff (rst_i)
      !wr_div |=> $stable(div_q);
   endproperty
   a_div_hold: assert property (p_div_hold) else $error("divider changed unwritten");

   property p_loaded_sticky;
      @(posedge core_clk_i) disable iff (rst_i)
      loaded_q |=> loaded_q;
   endproperty
   a_loaded_sticky: assert property (p_loaded_sticky) else $error("loaded flag dropped");

   property p_sec_rd;
      @(posedge core_clk_i) disable iff (rst_i)
      (rd_i && addr_i == `FCSIR_OFS_SEC) |=> (rdata_o == $past(sec_q));
   endproperty
   a_sec_rd: assert property (p_sec_rd) else $error("security readback wrong");

   // Once running, only the backdoor may touch the lock field
   property p_sec_run;
      @(posedge core_clk_i) disable iff (rst_i)
      !reset_seq_o |=> $stable(sec_q[`FCSIR_KEY_MSB:`FCSIR_RSV_LSB]);
   endproperty
   a_sec_run: assert property (p_sec_run) else $error("security upper bits moved");

   property p_unmapped_rd;
      @(posedge core_clk_i) disable iff (rst_i)
      (rd_i && addr_i > `FCSIR_OFS_ECCIX) |=> (rdata_o == `FCSIR_ZERO8);
   endproperty
   a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");

   property p_nv_req;
      @(posedge core_clk_i) disable iff (rst_i)
      !reset_seq_o |-> !nv_rd_req_o;
   endproperty
   a_nv_req: assert property (p_nv_req) else $error("fetch request after load");

   property p_nv_addr;
      @(posedge core_clk_i) disable iff (rst_i)
      nv_addr_o == `FCSIR_SEC_NV_ADDR;
   endproperty
   a_nv_addr: assert property (p_nv_addr) else $error("fetch address wrong");

   property p_seq_done;
      @(posedge core_clk_i) disable iff (rst_i)
      !reset_seq_o |=> !reset_seq_o;
   endproperty
   a_seq_done: assert property (p_seq_done) else $error("reset sequence restarted");

   property p_fault_key;
      @(posedge core_clk_i) disable iff (rst_i)
      (nv_rd_req_o && nv_rd_valid_i && nv_dbl_fault_i)
      |=> (!backdoor_enabled_o && part_secured_o);
   endproperty
   a_fault_key: assert property (p_fault_key) else $error("fault left part open");

   property p_cmdix_hold;
      @(posedge core_clk_i) disable iff (rst_i)
      !wr_cmdix |=> $stable(cmd_ix_q);
   endproperty
   a_cmdix_hold: assert property (p_cmdix_hold) else $error("command index moved");

   property p_eccix_hold;
      @(posedge core_clk_i) disable iff (rst_i)
      !wr_eccix |=> $stable(ecc_ix_q);
   endproperty
   a_eccix_hold: assert property (p_eccix_hold) else $error("ecc index moved");

   property p_eccix_rd;
      @(posedge core_clk_i) disable iff (rst_i)
      (rd_i && addr_i == `FCSIR_OFS_ECCIX)
      |=> (rdata_o == {`FCSIR_IX_PAD, $past(ecc_ix_q)});
   endproperty
   a_eccix_rd: assert property (p_eccix_rd) else $error("ecc index read wrong");
endmodule
`default_nettype wire

// file: dv/flash_ctrl_security_index_regs_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "fcsir_params.svh"
module flash_ctrl_security_index_regs_bench;
   // ------------------------------------------------------------
   // Stimulus and observed signals
   // ------------------------------------------------------------
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [4:0] addr_i = 5'h00;
   logic [7:0] wdata_i = 8'h00;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic cmd_done = 1'b1;
   logic nv_valid = 1'b0;
   logic [7:0] nv_data = 8'h00;
   logic nv_fault = 1'b0;
   logic unlock = 1'b0;
   logic [7:0] rdata_o;
   logic nv_rd_req_o;
   logic [22:0] nv_addr_o;
   logic reset_seq_o;
   logic [6:0] divide_ratio_field_o;
   logic divider_loaded_flag_o;
   logic backdoor_enabled_o;
   logic part_secured_o;
   logic [2:0] cmd_object_index_o;
   logic [2:0] ecc_result_index_o;
   logic [7:0] sv;
   int err_total = 0;
   int tests_run = 0;

   fcsir_regs dut_u
   (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .command_complete_flag_i(cmd_done),
      .nv_rd_req_o(nv_rd_req_o), .nv_addr_o(nv_addr_o), .nv_rd_valid_i(nv_valid),
      .nv_rd_data_i(nv_data), .nv_dbl_fault_i(nv_fault), .backdoor_unlock_i(unlock),
      .reset_seq_o(reset_seq_o), .divide_ratio_field_o(divide_ratio_field_o),
      .divider_loaded_flag_o(divider_loaded_flag_o),
      .backdoor_enabled_o(backdoor_enabled_o), .part_secured_o(part_secured_o),
      .cmd_object_index_o(cmd_object_index_o), .ecc_result_index_o(ecc_result_index_o)
   );

   initial
   begin
      forever #10 core_clk_i = ~core_clk_i;
   end

   // ------------------------------------------------------------
   // Access tasks
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [22:0] seen, input logic [22:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [4:0] a, input logic [7:0] exp, input string nm);
      @(posedge core_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge core_clk_i);
      rd_i <= 1'b0;
      #1 chk(nm, rdata_o, exp);
   endtask

   task automatic do_reset();
      @(posedge core_clk_i);
      rst_i <= 1'b1;
      cmd_done <= 1'b0;
      @(posedge core_clk_i);
      #1 chk("reset_seq", reset_seq_o, 1'b1);
      @(posedge core_clk_i);
      rst_i <= 1'b0;
   endtask

   task automatic nv_load(input logic [7:0] d, input logic f);
      int i;
      i = 0;
      while (nv_rd_req_o !== 1'b1 && i < 20)
      begin
         @(posedge core_clk_i);
         #1 i++;
      end
      chk("nv_req", nv_rd_req_o, 1'b1);
      chk("nv_addr", nv_addr_o, `FCSIR_SEC_NV_ADDR);
      @(posedge core_clk_i);
      nv_valid <= 1'b1;
      nv_data <= d;
      nv_fault <= f;
      @(posedge core_clk_i);
      nv_valid <= 1'b0;
      nv_fault <= 1'b0;
      cmd_done <= 1'b1;
      #1 chk("reset_seq_end", reset_seq_o, 1'b0);
      chk("nv_req_end", nv_rd_req_o, 1'b0);
   endtask

   task automatic wrap_up();
      $display("Checks %0d, errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial
   begin
      repeat (3000) @(posedge core_clk_i);
      err_total++;
      wrap_up();
   end

   initial
   begin
      // Every key and lock code once, reserved bits left erased
      for (int k = 0; k < 4; k++)
      begin
         sv = {k[1:0], 4'hF, 2'(3 - k)};
         do_reset();
         nv_load(sv, 1'b0);
         chk("key_enabled", backdoor_enabled_o, k == 2);
         chk("secured", part_secured_o, (3 - k) != 2);
         rd(5'h01, sv, "security_reg");
      end
      wr(5'h01, 8'h00);
      rd(5'h01, sv, "security_reg_ro");
      @(posedge core_clk_i);
      unlock <= 1'b1;
      @(posedge core_clk_i);
      unlock <= 1'b0;
      rd(5'h01, 8'hFE, "security_unlock");
      chk("secured_unlock", part_secured_o, 1'b0);
      // Double fault; divider written while the load is still pending
      do_reset();
      wr(5'h00, 8'h13);
      chk("reset_seq_wr", reset_seq_o, 1'b1);
      nv_load(8'h80, 1'b1);
      rd(5'h01, `FCSIR_SEC_FAULT, "security_fault");
      chk("key_fault", backdoor_enabled_o, 1'b0);
      chk("secured_fault", part_secured_o, 1'b1);
      rd(5'h00, 8'h93, "clock_divider_reg");
      chk("divide_ratio", divide_ratio_field_o, 7'h13);
      wr(5'h00, 8'h2F);
      rd(5'h00, 8'h93, "clock_divider_once");
      chk("divider_loaded", divider_loaded_flag_o, 1'b1);
      wr(5'h02, 8'hFD);
      wr(5'h03, 8'hFA);
      rd(5'h02, 8'h05, "cmd_index_reg");
      rd(5'h03, 8'h02, "ecc_index_reg");
      chk("cmd_object_index", cmd_object_index_o, 3'h5);
      chk("ecc_result_index", ecc_result_index_o, 3'h2);
      wr(5'h1F, 8'hFF);
      rd(5'h1F, 8'h00, "unmapped");
      wrap_up();
   end
endmodule
`default_nettype wire
